// file: design/acgc_global_ctl.sv
// Link global control: enables, shut-off, warm and cold link reset
//
// Contract
// - Enable bit 6 gates third input resume interrupt
// - Enable bit 5 gates second input resume interrupt
// - Enable bit 4 gates first input resume interrupt
// - Shut-off bit 3 releases all link outputs
// - Writing bit 2 starts a warm reset
// - Warm write ignored while bit clock runs
// - Warm bit self-clears once bit clock returns
// - Bit 1 low holds link in cold reset
// - Cold reset bit resets to zero
// - Cold reset bit survives suspend unchanged
// - Cold reset bit lives in core reset
// - Enabled input change sets status and interrupts
// - Disabled input change sets status only
// - Bit clock stopped after four edgeless clocks
module acgc_global_ctl
    import acgc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [LGC_W-1:0] reg_wdata,
    output logic [LGC_W-1:0] reg_rdata,
    input wire logic [STS_W-1:0] sts_clear,
    output logic [STS_W-1:0] sts,
    output logic irq,
    input wire logic link_bit_clock,
    input wire logic codec_serial_in_0,
    input wire logic codec_serial_in_1,
    input wire logic codec_serial_in_2,
    input wire logic [GPI_W-1:0] gp_in,
    input wire logic frame_sync_req,
    input wire logic frame_sdout,
    output logic link_sync,
    output logic link_sync_oe,
    output logic link_sdout,
    output logic link_sdout_oe,
    output logic link_reset_n,
    output logic link_reset_oe,
    output logic link_logic_rst,
    output logic bclk_stopped
);
    // Synchronised pins
    logic bclk_s;
    logic [NUM_SDIN-1:0] sdin_s;
    logic [GPI_W-1:0] gpi_s;

    acgc_sync #(
        .W(1 + NUM_SDIN + GPI_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({link_bit_clock, codec_serial_in_2, codec_serial_in_1,
              codec_serial_in_0, gp_in}),
        .dout({bclk_s, sdin_s, gpi_s})
    );

    // Control register fields
    logic sdin2_resume_irq_en_q;
    logic sdin1_resume_irq_en_q;
    logic sdin0_resume_irq_en_q;
    logic link_shutoff_q;
    logic warm_rst_q;
    logic warm_rst_d;
    logic cold_rst_n_q;
    logic gp_input_irq_en_q;

    // Bit clock watch
    logic bclk_prev_q;
    logic [STOP_CNT_W-1:0] stop_cnt_q;
    logic [STOP_CNT_W-1:0] stop_cnt_d;
    logic bclk_stopped_q;
    logic bclk_edge;
    logic bclk_gone;

    // Event detection
    logic [NUM_SDIN-1:0] sdin_prev_q;
    logic [GPI_W-1:0] gpi_prev_q;
    logic [2:0] gpi_seen_q;
    logic [NUM_SDIN-1:0] resume_evt;
    logic gpi_evt;
    logic [STS_W-1:0] sts_set;
    logic [STS_W-1:0] sts_q;
    logic [STS_W-1:0] sts_d;
    logic [STS_W-1:0] irq_en;
    logic irq_q;

    // Warm reset sequencer
    acgc_warm_state_t wr_state_q;
    acgc_warm_state_t wr_state_d;
    logic [PULSE_CNT_W-1:0] pulse_cnt_q;
    logic [PULSE_CNT_W-1:0] pulse_cnt_d;

    // Register access decode
    logic hit;
    logic ctl_wr;
    logic warm_req;
    logic warm_start;
    logic [LGC_W-1:0] ctl_view;
    logic [LGC_W-1:0] rdata_d;
    logic [LGC_W-1:0] rdata_q;

    // Link pin drivers
    logic sync_d;
    logic sdout_d;
    logic sync_q;
    logic sdout_q;
    logic oe_q;
    logic reset_n_q;
    logic logic_rst_q;

    function automatic logic [STOP_CNT_W-1:0] sat_inc(
        input logic [STOP_CNT_W-1:0] v
    );
        sat_inc = (v == STOP_CNT_W'(BCLK_STOP_CYC)) ? v : v + 1'b1;
    endfunction

    assign hit = (reg_addr == LGC_OFFSET);
    assign ctl_wr = reg_wr && hit;

    // Edge on the link clock restarts the silence count
    assign bclk_edge = bclk_s ^ bclk_prev_q;
    assign stop_cnt_d = bclk_edge ? '0 : sat_inc(stop_cnt_q);
    assign bclk_gone = (stop_cnt_d == STOP_CNT_W'(BCLK_STOP_CYC));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bclk_prev_q <= 1'b0;
            stop_cnt_q <= '0;
            bclk_stopped_q <= 1'b0;
        end else begin
            bclk_prev_q <= bclk_s;
            stop_cnt_q <= stop_cnt_d;
            bclk_stopped_q <= bclk_gone;
        end
    end

    // Warm reset only when the clock is known to be absent
    assign warm_req = ctl_wr && reg_wdata[WARM_RST_BIT];
    assign warm_start = warm_req && bclk_stopped_q && cold_rst_n_q
        && (wr_state_q == ACGC_WR_IDLE);

    always_comb begin
        wr_state_d = wr_state_q;
        pulse_cnt_d = pulse_cnt_q;
        warm_rst_d = warm_rst_q;
        case (wr_state_q)
            ACGC_WR_IDLE: begin
                if (warm_start) begin
                    wr_state_d = ACGC_WR_PULSE;
                    pulse_cnt_d = PULSE_CNT_W'(WARM_PULSE_CYC - 1);
                    warm_rst_d = 1'b1;
                end
            end
            ACGC_WR_PULSE: begin
                if (pulse_cnt_q == '0) begin
                    wr_state_d = ACGC_WR_WAIT;
                end else begin
                    pulse_cnt_d = pulse_cnt_q - 1'b1;
                end
            end
            ACGC_WR_WAIT: begin
                if (!bclk_stopped_q) begin
                    wr_state_d = ACGC_WR_IDLE;
                    warm_rst_d = 1'b0;
                end
            end
            default: begin
                wr_state_d = ACGC_WR_IDLE;
                pulse_cnt_d = '0;
                warm_rst_d = 1'b0;
            end
        endcase
        // Cold reset wipes any sequence in flight
        if (!cold_rst_n_q) begin
            wr_state_d = ACGC_WR_IDLE;
            pulse_cnt_d = '0;
            warm_rst_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_state_q <= ACGC_WR_IDLE;
            pulse_cnt_q <= '0;
            warm_rst_q <= LGC_RESET[WARM_RST_BIT];
        end else begin
            wr_state_q <= wr_state_d;
            pulse_cnt_q <= pulse_cnt_d;
            warm_rst_q <= warm_rst_d;
        end
    end

    // Plain read/write fields; only the core reset touches them, so a
    // suspend leaves the cold reset release in place.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdin2_resume_irq_en_q <= LGC_RESET[SDIN2_EN_BIT];
            sdin1_resume_irq_en_q <= LGC_RESET[SDIN1_EN_BIT];
            sdin0_resume_irq_en_q <= LGC_RESET[SDIN0_EN_BIT];
            link_shutoff_q <= LGC_RESET[SHUTOFF_BIT];
            cold_rst_n_q <= LGC_RESET[COLD_RST_N_BIT];
            gp_input_irq_en_q <= LGC_RESET[GPI_IRQ_EN_BIT];
        end else if (ctl_wr) begin
            sdin2_resume_irq_en_q <= reg_wdata[SDIN2_EN_BIT];
            sdin1_resume_irq_en_q <= reg_wdata[SDIN1_EN_BIT];
            sdin0_resume_irq_en_q <= reg_wdata[SDIN0_EN_BIT];
            link_shutoff_q <= reg_wdata[SHUTOFF_BIT];
            cold_rst_n_q <= reg_wdata[COLD_RST_N_BIT];
            gp_input_irq_en_q <= reg_wdata[GPI_IRQ_EN_BIT];
        end
    end

    // Upper bits are not stored and always read zero
    assign ctl_view = {{(LGC_W - LGC_USED_W){1'b0}},
                       sdin2_resume_irq_en_q, sdin1_resume_irq_en_q,
                       sdin0_resume_irq_en_q, link_shutoff_q, warm_rst_q,
                       cold_rst_n_q, gp_input_irq_en_q};
    assign rdata_d = (reg_rd && hit) ? ctl_view : '0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // A codec wakes the link by raising its data line while the clock
    // is absent; data toggling on a live link is not a resume.
    assign resume_evt = sdin_s & ~sdin_prev_q
        & {NUM_SDIN{bclk_stopped_q}};
    // Pins may sit high at reset: wait for sync chain and history
    assign gpi_evt = gpi_seen_q[2] && (gpi_s != gpi_prev_q);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sdin_prev_q <= '0;
            gpi_prev_q <= '0;
            gpi_seen_q <= '0;
        end else begin
            sdin_prev_q <= sdin_s;
            gpi_prev_q <= gpi_s;
            gpi_seen_q <= {gpi_seen_q[1:0], 1'b1};
        end
    end

    // Status is kept whatever the enables say; set beats clear
    assign sts_set = {resume_evt, gpi_evt};
    assign sts_d = (sts_q & ~sts_clear) | sts_set;
    assign irq_en = {sdin2_resume_irq_en_q,
                     sdin1_resume_irq_en_q,
                     sdin0_resume_irq_en_q,
                     gp_input_irq_en_q};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sts_q <= '0;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_q <= |(sts_d & irq_en);
        end
    end

    // Pin drive; the warm pulse overrides frame sync
    assign sync_d = (wr_state_q == ACGC_WR_PULSE)
        || (cold_rst_n_q && frame_sync_req);
    assign sdout_d = cold_rst_n_q && frame_sdout;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_q <= 1'b0;
            sdout_q <= 1'b0;
            oe_q <= 1'b1;
            reset_n_q <= 1'b0;
            logic_rst_q <= 1'b1;
        end else begin
            sync_q <= sync_d;
            sdout_q <= sdout_d;
            oe_q <= !link_shutoff_q;
            reset_n_q <= cold_rst_n_q;
            logic_rst_q <= !cold_rst_n_q;
        end
    end

    assign reg_rdata = rdata_q;
    assign sts = sts_q;
    assign irq = irq_q;
    assign link_sync = sync_q;
    assign link_sdout = sdout_q;
    assign link_reset_n = reset_n_q;
    // Shut-off floats all three outputs onto their pull-downs
    assign link_sync_oe = oe_q;
    assign link_sdout_oe = oe_q;
    assign link_reset_oe = oe_q;
    assign link_logic_rst = logic_rst_q;
    assign bclk_stopped = bclk_stopped_q;
endmodule // acgc_global_ctl

// file: design/acgc_pkg.sv
// Constants and types for the link global control block
package acgc_pkg;
    // Register placement and layout
    localparam logic [7:0] LGC_OFFSET = 8'h3c;
    localparam int LGC_W = 32;
    localparam int GPI_IRQ_EN_BIT = 0;
    localparam int COLD_RST_N_BIT = 1;
    localparam int WARM_RST_BIT = 2;
    localparam int SHUTOFF_BIT = 3;
    localparam int SDIN0_EN_BIT = 4;
    localparam int SDIN1_EN_BIT = 5;
    localparam int SDIN2_EN_BIT = 6;
    localparam int LGC_USED_W = 7;
    localparam logic [LGC_W-1:0] LGC_RESET = 32'h0000_0000;

    // Sticky event layout
    localparam int STS_W = 4;
    localparam int STS_GPI_BIT = 0;
    localparam int STS_SDIN0_BIT = 1;

    localparam int NUM_SDIN = 3;
    localparam int GPI_W = 4;

    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int BCLK_STOP_CYC = 4;
    localparam int WARM_PULSE_NS = 1000;
    localparam int WARM_PULSE_CYC =
        (WARM_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_CNT_W = 3;
    localparam int PULSE_CNT_W = 5;

    typedef enum logic [2:0] {
        ACGC_WR_IDLE = 3'b001,
        ACGC_WR_PULSE = 3'b010,
        ACGC_WR_WAIT = 3'b100
    } acgc_warm_state_t;
endpackage // acgc_pkg

// file: design/acgc_sync.sv
// Two-flop synchroniser for levels from outside the clock domain
module acgc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= din;
            stable_q <= meta_q;
        end
    end

    assign dout = stable_q;
endmodule // acgc_sync

// file: testbench/acgc_codec_model.sv
// Codec side model: bit clock source and serial data inputs
module acgc_codec_model (
    input wire logic run,
    input wire logic [2:0] wake,
    output logic bclk,
    output logic [2:0] sdin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial bclk = 1'b0;
    // Clock parks low while suspended, as a sleeping codec does
    always #160 bclk = run ? ~bclk : 1'b0;
    assign sdin = wake;
endmodule // acgc_codec_model

// file: testbench/acgc_global_ctl_asserts.sv
// Concurrent checks on the link global control ports
module acgc_global_ctl_asserts
    import acgc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [LGC_W-1:0] reg_wdata,
    input wire logic [LGC_W-1:0] reg_rdata,
    input wire logic frame_sync_req,
    input wire logic link_bit_clock,
    input wire logic link_sync,
    input wire logic link_sync_oe,
    input wire logic link_sdout_oe,
    input wire logic link_reset_n,
    input wire logic link_logic_rst,
    input wire logic bclk_stopped
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] sync_run_q;
    // Run length of sync high, to measure the warm reset pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            sync_run_q <= 8'h00;
        else
            sync_run_q <= link_sync ? sync_run_q + 8'h01 : 8'h00;
    end
    sequence s_wr;
        reg_wr && reg_addr == LGC_OFFSET;
    endsequence
    a_shutoff_oe: assert property (
        s_wr ##0 reg_wdata[3] |-> ##2 !link_sync_oe && !link_sdout_oe)
        else $error("link outputs driven in shut-off");
    a_cold_release: assert property (
        s_wr ##0 reg_wdata[1] |-> ##2 link_reset_n && !link_logic_rst)
        else $error("cold reset not released");
    a_cold_apply: assert property (
        s_wr ##0 !reg_wdata[1] |-> ##2 !link_reset_n && link_logic_rst)
        else $error("cold reset not applied");
    a_reset_cold: assert property (
        $past(sys_rst) |-> !link_reset_n && link_logic_rst)
        else $error("link not in cold reset after reset");
    a_warm_ignored: assert property (
        s_wr ##0 (reg_wdata[2] && !bclk_stopped && !link_sync)
        |-> ##2 (!link_sync || $past(frame_sync_req)))
        else $error("warm pulse with clock running");
    a_warm_width: assert property (
        $fell(link_sync) && link_reset_n && !$past(frame_sync_req, 2)
        |-> sync_run_q == 8'(WARM_PULSE_CYC))
        else $error("warm pulse width wrong");
    a_clk_seen: assert property (
        $changed(link_bit_clock) |-> ##[1:5] !bclk_stopped)
        else $error("running clock reported stopped");
    a_clk_stop: assert property (
        $stable(link_bit_clock) [*8] |-> ##2 bclk_stopped)
        else $error("idle clock not reported stopped");
    a_rdata_high: assert property (
        reg_rd |=> reg_rdata[LGC_W-1:LGC_USED_W] == '0)
        else $error("upper read bits not zero");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside read cycle");
endmodule // acgc_global_ctl_asserts

// file: testbench/test_aclink_global_control.sv
// Self-checking bench for the link global control block
module test_aclink_global_control
    import acgc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int COLD_HOLD_CYC = 50;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run = 1'b1;
    logic [2:0] wake = 3'h0;
    logic [3:0] gp_in = 4'h0;
    logic [3:0] sts_clear = 4'h0;
    logic [7:0] reg_addr = 8'h00;
    logic frame_sync_req = 1'b0;
    logic frame_sdout = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [3:0] sts;
    logic [2:0] sdin;
    logic irq, bclk, link_sync, link_sync_oe, link_sdout_oe;
    logic link_reset_n, link_logic_rst, bclk_stopped, link_sdout, link_reset_oe;
    int error_cnt = 0;
    int checks_done = 0;
    logic [31:0] row_wr [3] = '{32'hffff_fffb, 32'h0000_0006, 32'h0000_0072};
    logic [31:0] row_rd [3] = '{32'h0000_007b, 32'h0000_0002, 32'h0000_0072};
    always #20 clk = ~clk;
    acgc_codec_model codec (.run(run), .wake(wake), .bclk(bclk), .sdin(sdin));
    acgc_global_ctl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sts_clear(sts_clear), .sts(sts), .irq(irq),
        .link_bit_clock(bclk), .codec_serial_in_0(sdin[0]),
        .codec_serial_in_1(sdin[1]), .codec_serial_in_2(sdin[2]),
        .gp_in(gp_in), .frame_sync_req(frame_sync_req),
        .frame_sdout(frame_sdout), .link_sync(link_sync),
        .link_sync_oe(link_sync_oe), .link_sdout(link_sdout),
        .link_sdout_oe(link_sdout_oe), .link_reset_n(link_reset_n),
        .link_reset_oe(link_reset_oe), .link_logic_rst(link_logic_rst),
        .bclk_stopped(bclk_stopped));
    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [31:0] d);
        @(negedge clk);
        reg_addr = LGC_OFFSET;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("reg_rdata", exp, reg_rdata);
    endtask
    // Sticky bits hold until cleared, so each event is cleared here
    task automatic ev(input int b, input logic exp_irq);
        wait_cyc(4);
        chk("sts", 32'(1 << b), {28'h0, sts});
        chk("irq", {31'h0, exp_irq}, {31'h0, irq});
        sts_clear[b] = 1'b1;
        wait_cyc(1);
        sts_clear = 4'h0;
        wait_cyc(1);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        wait_cyc(8);
        sys_rst = 1'b0;
        rd(LGC_OFFSET, 32'h0);
        chk("link_reset_n", 32'h0, {31'h0, link_reset_n});
        rd(8'h40, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wr(row_wr[i]);
            rd(LGC_OFFSET, row_rd[i]);
            chk("link_reset_oe", {31'h0, !row_wr[i][SHUTOFF_BIT]},
                {31'h0, link_reset_oe});
        end
        $display("test rows done");
        wr(32'h0000_0002);
        gp_in = 4'h5;
        ev(STS_GPI_BIT, 1'b0);
        wr(32'h0000_0003);
        gp_in = 4'h4;
        ev(STS_GPI_BIT, 1'b1);
        $display("test gp done");
        run = 1'b0;
        wait_cyc(16);
        chk("bclk_stopped", 32'h1, {31'h0, bclk_stopped});
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < NUM_SDIN; i++) begin
                wr(32'h2 | (32'(e) << (SDIN0_EN_BIT + i)));
                wake[i] = 1'b1;
                ev(STS_SDIN0_BIT + i, e[0]);
                wake = 3'h0;
            end
        end
        $display("test resume done");
        wr(32'h0000_0006);
        wait_cyc(3);
        chk("link_sync", 32'h1, {31'h0, link_sync});
        rd(LGC_OFFSET, 32'h6);
        wait_cyc(40);
        rd(LGC_OFFSET, 32'h6);
        run = 1'b1;
        wait_cyc(20);
        rd(LGC_OFFSET, 32'h2);
        $display("test warm done");
        wr(32'h0000_0000);
        wait_cyc(COLD_HOLD_CYC);
        frame_sync_req = 1'b1;
        frame_sdout = 1'b1;
        wait_cyc(2);
        chk("link_logic_rst", 32'h1, {31'h0, link_logic_rst});
        chk("link_sdout", 32'h0, {31'h0, link_sdout});
        chk("link_sync", 32'h0, {31'h0, link_sync});
        wr(32'h0000_0002);
        wait_cyc(2);
        chk("link_sdout", 32'h1, {31'h0, link_sdout});
        chk("link_sync", 32'h1, {31'h0, link_sync});
        frame_sync_req = 1'b0;
        frame_sdout = 1'b0;
        sys_rst = 1'b1;
        wait_cyc(2);
        sys_rst = 1'b0;
        rd(LGC_OFFSET, 32'h0);
        wait_cyc(4);
        chk("sts", 32'h0, {28'h0, sts});
        $display("test cold done");
        test_done;
    end
    initial begin
        wait_cyc(5000);
        error_cnt++;
        test_done;
    end
endmodule // test_aclink_global_control
bind acgc_global_ctl acgc_global_ctl_asserts u_chk (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .frame_sync_req(frame_sync_req), .link_bit_clock(link_bit_clock),
    .link_sync(link_sync), .link_sync_oe(link_sync_oe),
    .link_sdout_oe(link_sdout_oe), .link_reset_n(link_reset_n),
    .link_logic_rst(link_logic_rst), .bclk_stopped(bclk_stopped));
